// [pbs_consts.svh]
// Purpose: shared constants of the pipelined burst sram port
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH

`define PBS_ADDR_W_DEF     17
`define PBS_DATA_W_DEF     36
`define PBS_LANE_W         9
`define PBS_BURST_W        2
`define PBS_BURST_LEN      4
`define PBS_PIPE_DEPTH     2
`define PBS_CNT_RST        2'h0
`define PBS_DATA_RST       1'b0

`endif

// [pbs_pkg.sv]
// Purpose: types of the pipelined burst sram port
// Assumes: nothing
// Notes:   constants live in pbs_consts.svh
package pbs_pkg;

    typedef enum logic [0:0]
    {
        PBS_IDLE  = 1'b0,
        PBS_BURST = 1'b1
    } pbs_burst_type;

    typedef enum logic [0:0]
    {
        PBS_LINEAR      = 1'b0,
        PBS_INTERLEAVED = 1'b1
    } pbs_order_type;

endpackage : pbs_pkg

// [pbs_mem.sv]
// Purpose: storage array with byte-lane writes and a registered read port
// Assumes: one clock, enable freezes the whole array and read register
// Notes:   array has no reset; only the read register does
`timescale 1ns/1ps
`include "pbs_consts.svh"

module pbs_mem
    import pbs_pkg::*;
#(
    parameter int ADDR_W = `PBS_ADDR_W_DEF,
    parameter int DATA_W = `PBS_DATA_W_DEF,
    parameter int LANES  = DATA_W / `PBS_LANE_W
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // access
    input  wire logic              en,
    input  wire logic [LANES-1:0]  wr_lane,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] wmerge;

    always_comb
    begin
        next_rdata = rdata;
        if (en && rd_en)
        begin
            next_rdata = store[addr];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= {DATA_W{`PBS_DATA_RST}};
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // lanes merged first so the array keeps a single writing process
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign wmerge[g*`PBS_LANE_W +: `PBS_LANE_W] = wr_lane[g]
                ? wdata[g*`PBS_LANE_W +: `PBS_LANE_W]
                : store[addr][g*`PBS_LANE_W +: `PBS_LANE_W];
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (en && (|wr_lane))
        begin
            store[addr] <= wmerge;
        end
    end

endmodule : pbs_mem

// [pbs_port.sv]
// Purpose: pipelined zero-turnaround sram port with a four-word burst counter
// Assumes: all inputs synchronous to clk_sys; data pin split in/out/oe_n
// Notes:   default 128K x 36; set ADDR_W 18, DATA_W 18 for 256K x 18
//
// Overview of operation
// - data transfer follows its command by two cycles
// - clock enable high freezes all registers, inputs other than output enable ignored
// - deselect starts nothing, pipeline still drains
// - bus floats two cycles after deselect or write
// - deselect when any chip select inactive at load
// - selected load captures address and control
// - deselected load terminates the running burst
// - advance steps counter, ignores external address
// - load and advances cycle through the four addresses of the aligned block, wrapping after the fourth
// - read_write_n at load picks burst direction
// - per-lane write enables, written two cycles later
// - byte enables ignored on reads
// - order select high interleaved, low linear
// - output enable high floats pins, asynchronously
// - drivers gated internally to read cycles
// - read data path registered; write data goes straight into the array
// - read and write may alternate back to back
// - 128K x 36 or 256K x 18 organisation
`timescale 1ns/1ps
`include "pbs_consts.svh"

module pbs_port
    import pbs_pkg::*;
#(
    parameter int ADDR_W = `PBS_ADDR_W_DEF,
    parameter int DATA_W = `PBS_DATA_W_DEF,
    parameter int LANES  = DATA_W / `PBS_LANE_W
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // control
    input  wire logic              clock_enable_n,
    input  wire logic              advance_load_n,
    input  wire logic              read_write_n,
    input  wire logic              chip_select_low_a,
    input  wire logic              chip_select_low_b,
    input  wire logic              chip_select_high,
    input  wire logic              burst_order_select,
    input  wire logic              output_enable_n,
    // address and byte enables
    input  wire logic [ADDR_W-1:0] address_in,
    input  wire logic [LANES-1:0]  byte_write_n,
    // data pins, split
    input  wire logic [DATA_W-1:0] data_io_in,
    output logic      [DATA_W-1:0] data_io_out,
    output logic                   data_io_oe_n
);

    // elaboration checks
    generate
        if (DATA_W % `PBS_LANE_W != 0 || LANES * `PBS_LANE_W != DATA_W)
        begin : g_bad_width
            $error("data width must be whole 9-bit lanes");
        end
        if (ADDR_W < `PBS_BURST_W + 1)
        begin : g_bad_addr
            $error("address too narrow for a four-word burst");
        end
    endgenerate

    // qualifiers
    logic                     ce_act;
    logic                     selected;
    logic                     load;
    pbs_order_type            order;

    // burst counter state
    pbs_burst_type            burst_state;
    pbs_burst_type            next_burst_state;
    logic [ADDR_W-1:0]        burst_base;
    logic [ADDR_W-1:0]        next_burst_base;
    logic [`PBS_BURST_W-1:0]  burst_cnt;
    logic [`PBS_BURST_W-1:0]  next_burst_cnt;
    logic                     burst_write;
    logic                     next_burst_write;
    logic [`PBS_BURST_W-1:0]  step_cnt;
    logic [`PBS_BURST_W-1:0]  step_low;

    // command stage one (address registers)
    logic                     s1_valid;
    logic                     next_s1_valid;
    logic                     s1_write;
    logic                     next_s1_write;
    logic [ADDR_W-1:0]        s1_addr;
    logic [ADDR_W-1:0]        next_s1_addr;
    logic [LANES-1:0]         s1_be_n;
    logic [LANES-1:0]         next_s1_be_n;

    // command stage two (data phase owner)
    logic                     s2_valid;
    logic                     next_s2_valid;
    logic                     s2_write;
    logic                     next_s2_write;
    logic [ADDR_W-1:0]        s2_addr;
    logic [ADDR_W-1:0]        next_s2_addr;
    logic [LANES-1:0]         s2_be_n;
    logic [LANES-1:0]         next_s2_be_n;

    // output driver gate
    logic                     out_drive;
    logic                     next_out_drive;

    // array side
    logic [LANES-1:0]         wr_lane;
    logic                     rd_en;

    assign ce_act   = !clock_enable_n;
    assign selected = !chip_select_low_a && !chip_select_low_b
                      && chip_select_high;
    assign load     = !advance_load_n;
    assign order    = pbs_order_type'(burst_order_select);

    // next burst offset relative to the loaded base
    assign step_cnt = burst_cnt + `PBS_BURST_W'(1);

    always_comb
    begin
        step_low = burst_base[`PBS_BURST_W-1:0] + step_cnt;
        if (order == PBS_INTERLEAVED)
        begin
            step_low = burst_base[`PBS_BURST_W-1:0] ^ step_cnt;
        end
    end

    // burst counter and stage one
    always_comb
    begin
        next_burst_state = burst_state;
        next_burst_base  = burst_base;
        next_burst_cnt   = burst_cnt;
        next_burst_write = burst_write;
        next_s1_valid    = s1_valid;
        next_s1_write    = s1_write;
        next_s1_addr     = s1_addr;
        next_s1_be_n     = s1_be_n;
        if (ce_act)
        begin
            next_s1_be_n = {LANES{1'b1}};
            if (load && selected)
            begin
                next_burst_state = PBS_BURST;
                next_burst_base  = address_in;
                next_burst_cnt   = `PBS_CNT_RST;
                next_burst_write = !read_write_n;
                next_s1_valid    = 1'b1;
                next_s1_write    = !read_write_n;
                next_s1_addr     = address_in;
                if (!read_write_n)
                begin
                    next_s1_be_n = byte_write_n;
                end
            end
            else if (load)
            begin
                // deselect: no new operation, older stages still drain
                next_burst_state = PBS_IDLE;
                next_s1_valid    = 1'b0;
            end
            else
            begin
                unique case (burst_state)
                    PBS_BURST:
                    begin
                        // external address is not looked at here
                        next_burst_cnt = step_cnt;
                        next_s1_valid  = 1'b1;
                        next_s1_write  = burst_write;
                        next_s1_addr   = {burst_base[ADDR_W-1:`PBS_BURST_W],
                                          step_low};
                        if (burst_write)
                        begin
                            next_s1_be_n = byte_write_n;
                        end
                    end
                    PBS_IDLE:
                    begin
                        next_s1_valid = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            burst_state <= PBS_IDLE;
            burst_base  <= '0;
            burst_cnt   <= `PBS_CNT_RST;
            burst_write <= 1'b0;
            s1_valid    <= 1'b0;
            s1_write    <= 1'b0;
            s1_addr     <= '0;
            s1_be_n     <= '1;
        end
        else
        begin
            burst_state <= next_burst_state;
            burst_base  <= next_burst_base;
            burst_cnt   <= next_burst_cnt;
            burst_write <= next_burst_write;
            s1_valid    <= next_s1_valid;
            s1_write    <= next_s1_write;
            s1_addr     <= next_s1_addr;
            s1_be_n     <= next_s1_be_n;
        end
    end

    // stage two and output gate; stages advance together, so a read may
    // sit right behind a write with no idle slot
    always_comb
    begin
        next_s2_valid  = s2_valid;
        next_s2_write  = s2_write;
        next_s2_addr   = s2_addr;
        next_s2_be_n   = s2_be_n;
        next_out_drive = out_drive;
        if (ce_act)
        begin
            next_s2_valid  = s1_valid;
            next_s2_write  = s1_write;
            next_s2_addr   = s1_addr;
            next_s2_be_n   = s1_be_n;
            next_out_drive = s2_valid && !s2_write;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s2_valid  <= 1'b0;
            s2_write  <= 1'b0;
            s2_addr   <= '0;
            s2_be_n   <= '1;
            out_drive <= 1'b0;
        end
        else
        begin
            s2_valid  <= next_s2_valid;
            s2_write  <= next_s2_write;
            s2_addr   <= next_s2_addr;
            s2_be_n   <= next_s2_be_n;
            out_drive <= next_out_drive;
        end
    end

    // write data is taken straight into the array at the data edge;
    // reads of the same edge belong to an older command, so no bypass
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign wr_lane[g] = s2_valid && s2_write && !s2_be_n[g];
        end
    endgenerate

    assign rd_en = s2_valid && !s2_write;

    pbs_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .LANES  (LANES)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .en      (ce_act),
        .wr_lane (wr_lane),
        .rd_en   (rd_en),
        .addr    (s2_addr),
        .wdata   (data_io_in),
        .rdata   (data_io_out)
    );

    // output enable is asynchronous; internal gate keeps it safe tied low
    assign data_io_oe_n = !(out_drive && !output_enable_n);

endmodule : pbs_port

// [pbs_port_monitor.sv]
// Purpose: concurrent checks on the pins of the sram port
// Assumes: bound to pbs_port; one clock domain
// Notes:   clock enable must stay low through each multi-cycle antecedent
`timescale 1ns/1ps
module pbs_port_monitor
    import pbs_pkg::*;
#(
    parameter int DATA_W = 36
)
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_b,
    // control
    input wire logic              clock_enable_n,
    input wire logic              advance_load_n,
    input wire logic              read_write_n,
    input wire logic              chip_select_low_a,
    input wire logic              chip_select_low_b,
    input wire logic              chip_select_high,
    input wire logic              output_enable_n,
    // data pins
    input wire logic [DATA_W-1:0] data_io_out,
    input wire logic              data_io_oe_n
);
    logic sel;
    assign sel = !chip_select_low_a && !chip_select_low_b && chip_select_high;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_load(logic rw);
        !clock_enable_n && !advance_load_n && sel && read_write_n == rw;
    endsequence
    sequence s_desel;
        !clock_enable_n && !advance_load_n && !sel;
    endsequence
    sequence s_adv;
        !clock_enable_n && advance_load_n && !output_enable_n;
    endsequence

    AST_OE_ASYNC: assert property (output_enable_n |-> data_io_oe_n)
        else $error("data pins driven while output enable high");
    AST_FREEZE: assert property (clock_enable_n |=> !$stable(output_enable_n)
        || ($stable(data_io_oe_n) && $stable(data_io_out)))
        else $error("outputs moved on a disabled edge");
    AST_WRITE_FLOAT: assert property (s_load(1'b0) ##1 (!clock_enable_n)[*2]
        |=> data_io_oe_n)
        else $error("bus driven in the data slot of a write");
    AST_DESEL_FLOAT: assert property (s_desel ##1 (!clock_enable_n)[*2]
        |=> data_io_oe_n)
        else $error("bus driven two cycles after a deselect");
    AST_READ_DRIVE: assert property (s_load(1'b1) ##1
        (!clock_enable_n && !output_enable_n)[*2] ##1 !output_enable_n |-> !data_io_oe_n)
        else $error("read data not driven two cycles after its load");
    AST_BURST_DRIVE: assert property (s_load(1'b1) ##1 s_adv[*3]
        ##1 (!clock_enable_n && !output_enable_n)[*2] ##1 !output_enable_n
        |-> !data_io_oe_n)
        else $error("last burst beat not driven");
    AST_ADV_IDLE: assert property (s_desel ##1 (!clock_enable_n && advance_load_n)[*3]
        |=> data_io_oe_n)
        else $error("advance after deselect restarted a burst");
    // one edge of grace: reset at time zero may only act on the first edge
    AST_RESET_FLOAT: assert property (disable iff (1'b0) !rst_b ##1 !rst_b
        |-> data_io_oe_n && data_io_out == '0)
        else $error("outputs not idle in reset");
endmodule : pbs_port_monitor

// [pbs_ctrl_model.sv]
// Purpose: controller side of the data pins; puts write data on the bus late
// Assumes: a write beat is announced in the cycle of its command
// Notes:   an undriven bus shows the inverse of its last level
`timescale 1ns/1ps
module pbs_ctrl_model
#(
    parameter int DATA_W = 36
)
(
    // clock and enable
    input  wire logic              clk_sys,
    input  wire logic              clock_enable_n,
    // write beat announced with its command
    input  wire logic              wr_go,
    input  wire logic [DATA_W-1:0] wr_dat,
    // device pins
    input  wire logic [DATA_W-1:0] data_io_out,
    input  wire logic              data_io_oe_n,
    output logic      [DATA_W-1:0] bus
);
    logic [1:0]        go = 2'h0;
    logic [DATA_W-1:0] d1, d2;
    logic [DATA_W-1:0] last = '0;

    // data follows its command by two enabled edges
    always @(posedge clk_sys)
        if (!clock_enable_n)
        begin
            go <= {go[0], wr_go};
            d1 <= wr_dat;
            d2 <= d1;
        end
    always @(posedge clk_sys)
        last <= bus;
    // floating bus toggles so a stale value never looks valid
    always_comb bus = go[1] ? d2 : (!data_io_oe_n ? data_io_out : ~last);
endmodule : pbs_ctrl_model

// [test_pipelined_burst_sram_port.sv]
// Purpose: self-checking run of the sram port against a reference array
// Assumes: 128K x 36 organisation, output enable mostly held low
// Notes:   inputs change at the falling edge; data slots checked at the next one
`timescale 1ns/1ps
module test_pipelined_burst_sram_port
    import pbs_pkg::*;
;
    logic        clk_sys, rst_b, clock_enable_n, advance_load_n, read_write_n;
    logic        chip_select_low_a, chip_select_low_b, chip_select_high;
    logic        burst_order_select, output_enable_n, data_io_oe_n, wr_go;
    logic        cen_n, oe_off, run, brw;
    logic [1:0]  cnt;
    logic [2:0]  cs;
    logic [3:0]  byte_write_n;
    logic [16:0] address_in, base, ea;
    logic [35:0] data_io_in, data_io_out, wr_dat;
    logic [35:0] mem  [int];
    logic [35:0] expv [int];
    int          kind [int];
    int          num_errors, n_compared, cyc;

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input logic drv, input logic [35:0] v);
        n_compared++;
        if (data_io_oe_n !== !drv || (drv && data_io_out !== v))
        begin
            num_errors++;
            $display("MISMATCH data_io exp %h/%b seen %h/%b", v, !drv, data_io_out,
                     data_io_oe_n);
        end
    endtask : chk

    // one edge: check the last data slot, drive, then update the reference
    task automatic cmd(input logic adv, rw, input logic [16:0] a, input logic [3:0] bw,
                       input logic [35:0] wd);
        @(negedge clk_sys);
        output_enable_n = oe_off;
        #1;
        if (kind.exists(cyc - 1))
            chk(kind[cyc - 1] == 1 && !oe_off, expv[cyc - 1]);
        clock_enable_n = cen_n;
        advance_load_n = adv;
        read_write_n = rw;
        {chip_select_low_a, chip_select_low_b, chip_select_high} = cs;
        address_in = a;
        byte_write_n = bw;
        wr_dat = wd;
        wr_go = 1'b0;
        if (!cen_n)
        begin
            kind[cyc + 2] = 0;
            expv[cyc + 2] = '0;
            if (!adv)
            begin
                run = (cs == 3'h1);
                base = a;
                cnt = 2'h0;
                brw = rw;
            end
            else
                cnt++;
            if (run)
            begin
                ea = {base[16:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
                wr_go = !brw;
                kind[cyc + 2] = brw;
                if (brw)
                    expv[cyc + 2] = mem[ea];
                for (int i = 0; i < 4; i++)
                    if (!brw && !bw[i])
                        mem[ea][9 * i +: 9] = wd[9 * i +: 9];
            end
            cyc++;
        end
    endtask : cmd

    task automatic desel(input logic [2:0] c);
        cs = c;
        cmd(1'b0, 1'b1, 17'h00012, 4'h0, 36'h0);
        cs = 3'h1;
    endtask : desel

    task automatic t_burst();
        burst_order_select = 1'b0;
        for (int i = 0; i < 4; i++)
            cmd(i > 0, 1'b0, i ? 17'h1FFFF : 17'h00012, 4'h0, 36'h123456780 + 36'(i));
        for (int i = 0; i < 9; i++)
            cmd(i > 0, 1'b1, i ? 17'h1FFFF : 17'h00012, 4'hF, 36'h0);
        desel(3'h5);
        desel(3'h5);
        desel(3'h5);
        $display("done linear burst write, read and wrap");
    endtask : t_burst

    task automatic t_lanes();
        burst_order_select = 1'b1;
        for (int i = 0; i < 4; i++)
            cmd(i > 0, 1'b0, 17'h00013, 4'hA, 36'hFFFFFFFFF - 36'(i));
        for (int i = 0; i < 4; i++)
            cmd(i > 0, 1'b1, 17'h00013, 4'h0, 36'h0);
        for (int i = 0; i < 3; i++)
            desel(3'h5);
        $display("done interleaved lane writes");
    endtask : t_lanes

    task automatic t_desel();
        logic [2:0] codes [3] = '{3'h5, 3'h3, 3'h0};
        foreach (codes[k])
        begin
            cmd(1'b0, 1'b1, 17'h00010, 4'h0, 36'h0);
            cmd(1'b1, 1'b1, 17'h00000, 4'h0, 36'h0);
            desel(codes[k]);
            for (int i = 0; i < 3; i++)
                cmd(1'b1, 1'b1, 17'h00011, 4'h0, 36'h0);
        end
        $display("done deselect codes");
    endtask : t_desel

    task automatic t_freeze();
        cmd(1'b0, 1'b1, 17'h00011, 4'h0, 36'h0);
        cmd(1'b1, 1'b1, 17'h00011, 4'h0, 36'h0);
        cen_n = 1'b1;
        for (int i = 0; i < 3; i++)
            cmd(1'b0, 1'b0, 17'h00012, 4'h0, 36'h0);
        cen_n = 1'b0;
        cmd(1'b1, 1'b1, 17'h00000, 4'h0, 36'h0);
        oe_off = 1'b1;
        cmd(1'b1, 1'b1, 17'h00000, 4'h0, 36'h0);
        oe_off = 1'b0;
        for (int i = 0; i < 5; i++)
            cmd(1'b0, 1'b1, 17'h00010 + 17'(i % 4), 4'h0, 36'h0);
        for (int i = 0; i < 3; i++)
            desel(3'h5);
        $display("done clock enable hold and output enable");
    endtask : t_freeze

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        // advance with no burst is a no-op, so nothing starts at release
        {rst_b, clock_enable_n, advance_load_n, read_write_n} = 4'h3;
        {chip_select_low_a, chip_select_low_b, chip_select_high} = 3'h1;
        {burst_order_select, output_enable_n, wr_go, run, oe_off, cen_n} = 6'h0;
        {address_in, byte_write_n, wr_dat, cyc, num_errors, n_compared} = '0;
        cs = 3'h1;
        repeat (5) @(negedge clk_sys);
        chk(1'b0, 36'h0);
        rst_b = 1'b1;
        t_burst();
        t_lanes();
        t_desel();
        t_freeze();
        close_out();
    end

    pbs_port DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .clock_enable_n(clock_enable_n),
        .advance_load_n(advance_load_n), .read_write_n(read_write_n),
        .chip_select_low_a(chip_select_low_a), .chip_select_low_b(chip_select_low_b),
        .chip_select_high(chip_select_high), .burst_order_select(burst_order_select),
        .output_enable_n(output_enable_n), .address_in(address_in),
        .byte_write_n(byte_write_n), .data_io_in(data_io_in),
        .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n));

    pbs_ctrl_model u_ctrl (
        .clk_sys(clk_sys), .clock_enable_n(clock_enable_n), .wr_go(wr_go),
        .wr_dat(wr_dat), .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n),
        .bus(data_io_in));
endmodule : test_pipelined_burst_sram_port

bind pbs_port pbs_port_monitor #(.DATA_W(DATA_W)) u_mon (
    .clk_sys(clk_sys), .rst_b(rst_b), .clock_enable_n(clock_enable_n),
    .advance_load_n(advance_load_n), .read_write_n(read_write_n),
    .chip_select_low_a(chip_select_low_a), .chip_select_low_b(chip_select_low_b),
    .chip_select_high(chip_select_high), .output_enable_n(output_enable_n),
    .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n));
